// *** src/srf_map.svh ***
// Register offsets, field positions, reset values and encodings of the receive framing block.
`ifndef SRF_MAP_SVH
`define SRF_MAP_SVH
`define SRF_ADDR_CONTROL 4'h0
`define SRF_ADDR_FRAME 4'h4
`define SRF_ADDR_DATA 4'h8
`define SRF_ADDR_STATUS 4'hC
`define SRF_FRAME_RESET 32'h0000_0000
`define SRF_FRAME_WMASK 32'hFFFF_7FF0
`define SRF_BIT_ENABLE 0
`define SRF_BIT_PHASE 31
`define SRF_POS_P2CNT 24
`define SRF_POS_P2BITS 21
`define SRF_POS_COMP 19
`define SRF_BIT_IGNORE 18
`define SRF_POS_DELAY 16
`define SRF_POS_P1CNT 8
`define SRF_POS_P1BITS 5
`define SRF_BIT_REVERSE 4
`define SRF_COMP_MSB 2'h0
`define SRF_COMP_LSB 2'h1
`define SRF_COMP_MULAW 2'h2
`define SRF_COMP_ALAW 2'h3
`endif

// *** src/srf_pkg.sv ***
// Types shared by the receive framing block.
package srf_pkg;
  typedef struct packed {
    logic dual_phase;
    logic [6:0] p2_count;
    logic [2:0] p2_bits;
    logic [1:0] compand;
    logic ignore_sync;
    logic [1:0] delay;
    logic [6:0] p1_count;
    logic [2:0] p1_bits;
    logic reverse;
  } srf_cfg_type;
  typedef struct packed {
    logic valid;
    logic phase2;
    logic [31:0] data;
  } srf_word_type;
  typedef enum logic [1:0] {SRF_IDLE, SRF_DELAY, SRF_DATA} srf_state_type;
endpackage

// *** src/srf_receiver.sv ***
// Receive framing engine with its control registers and serial front end.
// Functional notes
// RQ1: Enable bit low holds receiver in reset.
// RQ2: Phase bit selects single or dual frame.
// RQ3: Phase-2 word length from encoded field.
// RQ4: Companding zero: no expansion, MSB first.
// RQ5: Companding one: 8-bit words LSB first.
// RQ6: Codes two/three expand mu-law/A-law.
// RQ7: Companding only honoured with 8-bit words; code one also gives LSB first on 32-bit words when bit reverse is set.
// RQ8: Ignore bit low: later syncs restart.
// RQ9: Ignore bit high: later syncs disregarded.
// RQ10: Phase-1 word count is field plus one.
// RQ11: Phase-1 word length same encoding.
// RQ12: Data delay of zero, one, two bits.
// RQ13: Bit reverse receives 32-bit LSB first; the code reverses only with companding code one.
// RQ14: Count bits and words per active phase.
// RQ15: Synchronise bit clock and sync inputs.
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/1ns
`include "srf_map.svh"
module srf_receiver
#(
  parameter int DATA_BITS = 32,
  parameter int COUNT_BITS = 7
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire logic serial_clk,
  input wire logic frame_sync,
  input wire logic serial_data,
  output srf_pkg::srf_word_type rx_word
);
  logic enable_q;
  logic [31:0] frame_q;
  srf_pkg::srf_cfg_type cfg;
  logic [2:0] clk_sync_q;
  logic [1:0] fs_sync_q;
  logic [1:0] dat_sync_q;
  logic fs_prev_q;
  logic sclk_rise;
  logic fs_rise;
  srf_pkg::srf_state_type state_q;
  logic [5:0] bit_cnt_q;
  logic [6:0] word_cnt_q;
  logic phase2_q;
  logic [31:0] shift_q;
  logic [5:0] word_bits;
  logic [2:0] bits_code;
  logic [6:0] word_limit;
  logic [31:0] shift_d;
  logic lsb_first;
  logic last_bit;
  logic overrun_q;
  logic sync_err_q;
  logic [31:0] data_q;
  logic unread_q;
  logic [15:0] mu_lin;
  logic [15:0] a_lin;

  // The word type and the frame fields are fixed, so other widths are refused.
  if (DATA_BITS != 32 || COUNT_BITS != 7)
  begin : g_width_check
    $error("srf_receiver serves only 32-bit words and 7-bit word counts");
  end

  // Reserved bits 15 and 3:0 never reach the sequencer.
  always_comb
  begin
    cfg.dual_phase = frame_q[`SRF_BIT_PHASE]; // RQ2
    cfg.p2_count = frame_q[`SRF_POS_P2CNT +: 7]; // RQ2
    cfg.p2_bits = frame_q[`SRF_POS_P2BITS +: 3]; // RQ3
    cfg.compand = frame_q[`SRF_POS_COMP +: 2]; // RQ4
    cfg.ignore_sync = frame_q[`SRF_BIT_IGNORE]; // RQ8
    cfg.delay = frame_q[`SRF_POS_DELAY +: 2]; // RQ12
    cfg.p1_count = frame_q[`SRF_POS_P1CNT +: 7]; // RQ10
    cfg.p1_bits = frame_q[`SRF_POS_P1BITS +: 3]; // RQ11
    cfg.reverse = frame_q[`SRF_BIT_REVERSE]; // RQ13
  end

  // Reserved codes fall back to 8 bits so the bit counter always has an end.
  function automatic logic [5:0] bits_of(input logic [2:0] code);
    logic [5:0] r;
    r = 6'd8;
    unique case (code)
      3'h0: r = 6'd8;
      3'h1: r = 6'd12;
      3'h2: r = 6'd16;
      3'h3: r = 6'd20;
      3'h4: r = 6'd24;
      3'h5: r = 6'd32;
      default: r = 6'd8;
    endcase
    return r;
  endfunction

  // Mu-law expansion to a 16-bit linear value, placed in the low half of the word and sign-extended through the upper half.
  function automatic logic [15:0] mulaw(input logic [7:0] c);
    logic [7:0] v;
    logic [14:0] mag;
    v = ~c;
    mag = 15'((({8'h0, v[3:0], 3'h0} + 15'h0084) << v[6:4]) - 15'h0084);
    return v[7] ? 16'(-$signed({1'b0, mag})) : {1'b0, mag};
  endfunction

  // A-law expansion to a 16-bit linear value.
  function automatic logic [15:0] alaw(input logic [7:0] c);
    logic [7:0] v;
    logic [14:0] mag;
    v = c ^ 8'h55;
    if (v[6:4] == 3'h0)
      mag = {7'h0, v[3:0], 4'h8};
    else
      mag = 15'(({6'h0, 1'b1, v[3:0], 4'h8}) << (v[6:4] - 3'h1));
    return v[7] ? {1'b0, mag} : 16'(-$signed({1'b0, mag}));
  endfunction

  // Both expansions run every cycle; only the selected one reaches the word.
  assign mu_lin = mulaw(shift_d[7:0]); // RQ6
  assign a_lin = alaw(shift_d[7:0]); // RQ6

  // Software register writes.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      enable_q <= 1'b0;
      frame_q <= `SRF_FRAME_RESET;
    end
    else if (reg_write)
    begin
      if (reg_addr == `SRF_ADDR_CONTROL)
        enable_q <= reg_wdata[`SRF_BIT_ENABLE];
      if (reg_addr == `SRF_ADDR_FRAME)
        frame_q <= reg_wdata & `SRF_FRAME_WMASK;
    end
  end

  // Read data stand in the cycle after the strobe only.
  always_ff @(posedge clk)
  begin
    if (reset || !reg_read)
      reg_rdata <= 32'h0000_0000;
    else
      unique case (reg_addr)
        `SRF_ADDR_CONTROL: reg_rdata <= {31'h0, enable_q};
        `SRF_ADDR_FRAME: reg_rdata <= frame_q;
        `SRF_ADDR_DATA: reg_rdata <= data_q;
        `SRF_ADDR_STATUS: reg_rdata <= {29'h0, sync_err_q, overrun_q, rx_word.valid};
        default: reg_rdata <= 32'h0000_0000;
      endcase
  end

  // Pins pass two flops first; the third clock flop only feeds the edge detector.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      clk_sync_q <= 3'h0;
      fs_sync_q <= 2'h0;
      dat_sync_q <= 2'h0;
    end
    else
    begin
      clk_sync_q <= {clk_sync_q[1:0], serial_clk}; // RQ15
      fs_sync_q <= {fs_sync_q[0], frame_sync}; // RQ15
      dat_sync_q <= {dat_sync_q[0], serial_data}; // RQ15
    end
  end

  // Data and sync are sampled on the falling bit-clock edge, the usual receive edge.
  assign sclk_rise = clk_sync_q[2] & ~clk_sync_q[1];
  assign fs_rise = sclk_rise & fs_sync_q[1] & ~fs_prev_q;

  always_ff @(posedge clk)
  begin
    if (reset)
      fs_prev_q <= 1'b0;
    else if (sclk_rise)
      fs_prev_q <= fs_sync_q[1];
  end

  assign bits_code = phase2_q ? cfg.p2_bits : cfg.p1_bits; // RQ3 RQ11
  assign word_bits = bits_of(bits_code); // RQ14
  assign word_limit = phase2_q ? cfg.p2_count : cfg.p1_count; // RQ2 RQ10
  // Companding takes effect with 8-bit words; reverse needs 32-bit words and companding code one.
  assign lsb_first = ((cfg.compand == `SRF_COMP_LSB) && (bits_code == 3'h0))
    || (cfg.reverse && (bits_code == 3'h5) && (cfg.compand == `SRF_COMP_LSB)); // RQ5 RQ7 RQ13
  assign shift_d = lsb_first ? {dat_sync_q[1], shift_q[31:1]}
    : {shift_q[30:0], dat_sync_q[1]}; // RQ4
  assign last_bit = (bit_cnt_q == word_bits - 6'd1);

  // Frame sequencer.
  always_ff @(posedge clk)
  begin
    if (reset || !enable_q) // RQ1
    begin
      state_q <= srf_pkg::SRF_IDLE;
      bit_cnt_q <= 6'h0;
      word_cnt_q <= 7'h0;
      phase2_q <= 1'b0;
      shift_q <= 32'h0000_0000;
      sync_err_q <= 1'b0;
    end
    else if (fs_rise && (state_q == srf_pkg::SRF_IDLE || !cfg.ignore_sync)) // RQ8 RQ9
    begin
      if (state_q != srf_pkg::SRF_IDLE)
        sync_err_q <= 1'b1; // RQ8
      phase2_q <= 1'b0;
      bit_cnt_q <= 6'h0;
      word_cnt_q <= 7'h0;
      shift_q <= 32'h0000_0000;
      // With no delay the first data bit arrives beside the sync.
      if (cfg.delay == 2'h0)
      begin
        state_q <= srf_pkg::SRF_DATA;
        shift_q <= shift_d;
        bit_cnt_q <= 6'h1;
      end
      else if (cfg.delay == 2'h1)
        state_q <= srf_pkg::SRF_DATA;
      else
        state_q <= srf_pkg::SRF_DELAY; // RQ12
    end
    else if (sclk_rise)
    begin
      unique case (state_q)
        srf_pkg::SRF_IDLE:
        begin
        end
        srf_pkg::SRF_DELAY:
          state_q <= srf_pkg::SRF_DATA;
        srf_pkg::SRF_DATA:
        begin
          shift_q <= shift_d;
          if (last_bit) // RQ14
          begin
            bit_cnt_q <= 6'h0;
            if (word_cnt_q == word_limit)
            begin
              word_cnt_q <= 7'h0;
              if (cfg.dual_phase && !phase2_q) // RQ2 RQ14
                phase2_q <= 1'b1;
              else
              begin
                phase2_q <= 1'b0;
                state_q <= srf_pkg::SRF_IDLE;
              end
            end
            else
              word_cnt_q <= 7'(word_cnt_q + 7'h1);
          end
          else
            bit_cnt_q <= 6'(bit_cnt_q + 6'h1);
        end
      endcase
    end
  end

  // Completed word: justify, expand and post to the data register.
  always_ff @(posedge clk)
  begin
    if (reset || !enable_q) // RQ1
    begin
      rx_word <= '0;
      data_q <= 32'h0000_0000;
      overrun_q <= 1'b0;
      unread_q <= 1'b0;
    end
    else
    begin
      rx_word.valid <= 1'b0;
      if (sclk_rise && state_q == srf_pkg::SRF_DATA && last_bit
        && !(fs_rise && !cfg.ignore_sync))
      begin
        rx_word.valid <= 1'b1;
        rx_word.phase2 <= phase2_q;
        if (bits_code == 3'h0 && cfg.compand == `SRF_COMP_MULAW) // RQ6 RQ7
          rx_word.data <= {{16{mu_lin[15]}}, mu_lin};
        else if (bits_code == 3'h0 && cfg.compand == `SRF_COMP_ALAW) // RQ6 RQ7
          rx_word.data <= {{16{a_lin[15]}}, a_lin};
        else if (lsb_first)
          rx_word.data <= shift_d >> (6'd32 - word_bits); // RQ5 RQ13
        else
          rx_word.data <= shift_d & ((32'h1 << word_bits) - 32'h1); // RQ4
      end
      if (rx_word.valid)
        data_q <= rx_word.data;
      // Posting a word beats a read of the one before it in the same cycle.
      if (rx_word.valid && unread_q)
        overrun_q <= 1'b1;
      if (rx_word.valid)
        unread_q <= 1'b1;
      else if (reg_read && reg_addr == `SRF_ADDR_DATA)
        unread_q <= 1'b0;
    end
  end
endmodule

// *** sim/srf_asserts.sv ***
// Port checker for the receive framing block, bound at the foot of this file.
`timescale 1ns/1ns
module srf_asserts
(
  input logic clk,
  input logic reset,
  input logic [3:0] reg_addr,
  input logic [31:0] reg_wdata,
  input logic reg_write,
  input logic reg_read,
  input logic [31:0] reg_rdata,
  input logic serial_clk,
  input logic frame_sync,
  input logic serial_data,
  input srf_pkg::srf_word_type rx_word
);
  logic en_q;
  logic [31:0] frm_q;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  always_ff @(posedge clk)
  begin
    if (reset) en_q <= 1'h0;
    else if (reg_write && reg_addr == 4'h0) en_q <= reg_wdata[0];
  end
  always_ff @(posedge clk)
  begin
    if (reset) frm_q <= 32'h0;
    else if (reg_write && reg_addr == 4'h4) frm_q <= reg_wdata;
  end
  property p_off; !en_q && !$past(en_q) |-> rx_word == '0; endproperty
  a_off: assert property (p_off) else $error("word while off");
  property p_frm; reg_read && reg_addr == 4'h4 |=> reg_rdata == (frm_q & 32'hFFFF_7FF0); endproperty
  a_frm: assert property (p_frm) else $error("bad readback");
  property p_syn; $fell(serial_clk) |-> !rx_word.valid ##1 !rx_word.valid; endproperty
  a_syn: assert property (p_syn) else $error("word too early");
  property p_one; rx_word.valid |=> !rx_word.valid; endproperty
  a_one: assert property (p_one) else $error("long valid");
  property p_ph; rx_word.valid && !frm_q[31] |-> !rx_word.phase2; endproperty
  a_ph: assert property (p_ph) else $error("phase two word");
  property p_w8; rx_word.valid && frm_q[23:19] == 5'h0 && frm_q[7:5] == 3'h0
    |-> rx_word.data < 32'h100; endproperty
  a_w8: assert property (p_w8) else $error("wide byte word");
  property p_w16; rx_word.valid && !frm_q[31] && frm_q[7:5] == 3'h2
    |-> rx_word.data < 32'h1_0000; endproperty
  a_w16: assert property (p_w16) else $error("wide half word");
  property p_ign; reg_read && reg_addr == 4'hC && en_q && frm_q[18] |=> !reg_rdata[2]; endproperty
  a_ign: assert property (p_ign) else $error("restart flagged");
endmodule
bind srf_receiver srf_asserts chk (.clk, .reset, .reg_addr, .reg_wdata, .reg_write,
  .reg_read, .reg_rdata, .serial_clk, .frame_sync, .serial_data, .rx_word);

// *** sim/srf_codec.sv ***
// Behavioural serial codec driving bit clock, frame sync and data.
`timescale 1ns/1ns
module srf_codec
(
  output logic serial_clk = 1'h0,
  output logic frame_sync = 1'h0,
  output logic serial_data = 1'h0
);
  // The clock stands low between frames. Sync rises while the clock is low and falls on a rising edge, where data change; both
  // are sampled on the falling one; the data line flips where the next rise would be,
  // so a receiver that samples too late sees a wrong bit, not a stale copy.
  task automatic send(input logic [31:0] v, input int n);
    #13 frame_sync = 1'h1;
    #200 serial_clk = 1'h1;
    #200 serial_clk = 1'h0;
    for (int i = n - 1; i >= 0; i--)
    begin
      #200 serial_clk = 1'h1;
      frame_sync = 1'h0;
      serial_data = v[i];
      #200 serial_clk = 1'h0;
    end
    #200 serial_data = ~serial_data;
  endtask
endmodule

// *** sim/tb_top.sv ***
// Self-checking bench: register traffic plus serial frames from the codec model.
`timescale 1ns/1ns
module tb_top;
  logic clk = 1'h0, reset = 1'h1, reg_write = 1'h0, reg_read = 1'h0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic serial_clk, frame_sync, serial_data;
  srf_pkg::srf_word_type rx_word;
  logic [32:0] got[$];
  int err_total = 0, checks = 0, cycles = 0;
  srf_receiver dut (.clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .serial_clk, .frame_sync, .serial_data, .rx_word);
  srf_codec codec (.serial_clk, .frame_sync, .serial_data);
  initial forever #25 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (rx_word.valid === 1'h1) got.push_back({rx_word.phase2, rx_word.data});
    if (cycles == 10000) wrap_up(1);
  end
  task automatic wrap_up(input int t);
    err_total += t;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [32:0] a, input logic [32:0] e);
    checks++;
    if (a !== e) $display("BAD %0t %h %h", $time, a, e);
    if (a !== e) err_total++;
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    {reg_write, reg_read, reg_addr, reg_wdata} <= {w, ~w, a, d};
    @(posedge clk);
    {reg_write, reg_read} <= 2'h0;
    #1 if (!w) cmp({1'h0, reg_rdata}, {1'h0, d});
  endtask
  // The receiver is disabled before each frame so sequencer and status start clean.
  task automatic frame(input logic [31:0] cfg, input logic p, input logic [31:0] v,
    input int n, input int k, input logic [31:0] e);
    got = {};
    bus(1'h1, 4'h0, 32'h0);
    bus(1'h1, 4'h4, cfg);
    bus(1'h1, 4'h0, {31'h0, k != 0});
    if (p) codec.send(32'hA, 4);
    codec.send(v, n);
    for (int i = 0; i < 20 && got.size() < k; i++) @(posedge clk);
    cmp(33'(got.size()), 33'(k));
    if (got.size() > 0) cmp(got[0], {1'h0, e});
  endtask
  task automatic t_regs();
    bus(1'h0, 4'h4, 32'h0);
    bus(1'h1, 4'h4, 32'hFFFF_FFFF);
    bus(1'h0, 4'h4, 32'hFFFF_7FF0);
    bus(1'h0, 4'h2, 32'h0);
  endtask
  task automatic t_modes();
    frame(32'h1_0000, 1'h0, 32'hA5, 8, 1, 32'hA5);
    frame(32'h9_0000, 1'h0, 32'h3A, 8, 1, 32'h5C);
    frame(32'h11_0000, 1'h0, 32'hFF, 8, 1, 32'h0);
    frame(32'h19_0000, 1'h0, 32'hD5, 8, 1, 32'h8);
    frame(32'h11_0040, 1'h0, 32'hFF, 16, 1, 32'hFF);
    frame(32'h9_00B0, 1'h0, 32'h1, 32, 1, 32'h8000_0000);
    frame(32'h1_0000, 1'h0, 32'hA5, 8, 0, 32'h0);
  endtask
  task automatic t_dual();
    frame(32'h8041_0100, 1'h0, 32'h1234_ABCD, 32, 3, 32'h12);
    cmp(got[1], 33'h34);
    cmp(got[2], 33'h1_0000_ABCD);
    bus(1'h0, 4'hC, 32'h2);
  endtask
  task automatic t_sync();
    frame(32'h1_0000, 1'h1, 32'h5C, 8, 1, 32'h5C);
    bus(1'h0, 4'hC, 32'h4);
    bus(1'h0, 4'h8, 32'h5C);
    frame(32'h5_0000, 1'h1, 32'h5C, 8, 1, 32'hAA);
    bus(1'h0, 4'hC, 32'h0);
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    reset <= 1'h0;
    t_regs();
    t_modes();
    t_dual();
    t_sync();
    wrap_up(0);
  end
endmodule
